/* logic/wwdt_cfg.svh */
// Offsets, field positions, reset values and timing counts of the watchdog.
`ifndef WWDT_CFG_SVH
`define WWDT_CFG_SVH
`define WWDT_CR_OFF     4'h0
`define WWDT_MR_OFF     4'h4
`define WWDT_SR_OFF     4'h8
`define WWDT_MR_RST     32'h3FFF2FFF
`define WWDT_KEY        8'hA5
`define WWDT_KEY_HI     31
`define WWDT_KEY_LO     24
`define WWDT_RSTT_BIT   0
`define WWDT_WDV_HI     11
`define WWDT_WDV_LO     0
`define WWDT_FIEN_BIT   12
`define WWDT_RSTEN_BIT  13
`define WWDT_RPROC_BIT  14
`define WWDT_DIS_BIT    15
`define WWDT_WDD_HI     27
`define WWDT_WDD_LO     16
`define WWDT_DBGH_BIT   28
`define WWDT_IDLH_BIT   29
`define WWDT_UNF_BIT    0
`define WWDT_ERR_BIT    1
`define WWDT_PRESC_DIV  128
`define WWDT_PRESC_W    7
`define WWDT_RESP_OKAY  2'h0
`define WWDT_RESP_SLV   2'h2
`endif

/* logic/wwdt_pkg.sv */
// Types shared by the watchdog modules.
`include "wwdt_cfg.svh"
package wwdt_pkg;
    typedef logic [31:0] wwdt_word_t;
    typedef logic [3:0]  wwdt_addr_t;
    typedef logic [11:0] wwdt_cnt_t;

    typedef struct packed {
        logic [`WWDT_PRESC_W-1:0] cnt;
        logic                     tick;
    } wwdt_presc_s;

    typedef struct packed {
        logic [29:0] mode;
        logic        mode_done;
        wwdt_cnt_t   cnt;
        logic        unf;
        logic        err;
        logic        fault;
        logic        irq;
        logic        proc_req;
        logic        all_req;
        logic        aw_hold;
        wwdt_addr_t  aw_addr;
        logic        w_hold;
        wwdt_word_t  w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        wwdt_word_t  rdata;
    } wwdt_state_s;
endpackage

/* logic/wwdt_presc.sv */
// Slow-clock prescaler that gives one tick per PRESC_DIV slow-clock enables.
`timescale 1ns/1ns
`include "wwdt_cfg.svh"
module wwdt_presc #(
    parameter int PRESC_DIV = `WWDT_PRESC_DIV
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic clr,
    input  wire logic slow_en,
    output logic      tick
);
    import wwdt_pkg::*;

    localparam logic [`WWDT_PRESC_W-1:0] LAST = (`WWDT_PRESC_W)'(PRESC_DIV - 1);

    wwdt_presc_s s_reg;
    wwdt_presc_s s_next;

    // A clear wins over a slow enable so that a restart starts a full period.
    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (clr) begin
            s_next.cnt = '0;
        end else if (slow_en) begin
            if (s_reg.cnt == LAST) begin
                s_next.cnt  = '0;
                s_next.tick = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;
endmodule // wwdt_presc

/* logic/wwdt_top.sv */
// Windowed watchdog timer with its AXI4-Lite register slave.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
`include "wwdt_cfg.svh"
module wwdt_top #(
    parameter int PRESC_DIV = `WWDT_PRESC_DIV
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             slow_clk_en,
    input  wire logic             debug_state,
    input  wire logic             idle_mode,
    input  wire wwdt_pkg::wwdt_addr_t s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire wwdt_pkg::wwdt_word_t s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire wwdt_pkg::wwdt_addr_t s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output wwdt_pkg::wwdt_word_t  s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    output logic                  wdt_fault,
    output logic                  fault_irq,
    output logic                  proc_reset_req,
    output logic                  all_reset_req
);
    import wwdt_pkg::*;

    localparam wwdt_word_t MR_RST = `WWDT_MR_RST;

    wwdt_state_s s_reg;
    wwdt_state_s s_next;
    wwdt_state_s rst_val;

    logic       presc_tick;
    logic       presc_clr;
    logic       wr_go;
    logic       wr_mapped;
    logic       mw_ok;
    logic       cr_key_ok;
    logic       cr_bad;
    logic       rstt_req;
    logic       win_bad;
    logic       restart_ok;
    logic       err_ev;
    logic       unf_ev;
    logic       running;
    logic       ar_go;
    logic       sr_rd;
    wwdt_word_t mode_full;
    wwdt_word_t mode_wr;
    wwdt_cnt_t  counter_reload_value;
    wwdt_cnt_t  restart_window_limit;

    // The prescaler restarts on a configuration write or a good restart, not on an underflow reload, so a restart gives a whole tick period.
    wwdt_presc #(
        .PRESC_DIV (PRESC_DIV)
    ) u_presc (
        .core_clk (core_clk),
        .rst      (rst),
        .clr      (presc_clr),
        .slow_en  (slow_clk_en),
        .tick     (presc_tick)
    );

    // Reset image: configuration defaults, counter full and running, ready to accept.
    always_comb begin
        rst_val          = '0;
        rst_val.mode     = MR_RST[29:0];
        rst_val.cnt      = MR_RST[`WWDT_WDV_HI:`WWDT_WDV_LO];
        rst_val.awready  = 1'b1;
        rst_val.wready   = 1'b1;
        rst_val.arready  = 1'b1;
    end

    // Decoded fields of the configuration register.
    assign mode_full = {2'h0, s_reg.mode};
    assign counter_reload_value       = mode_full[`WWDT_WDV_HI:`WWDT_WDV_LO];
    assign restart_window_limit       = mode_full[`WWDT_WDD_HI:`WWDT_WDD_LO];

    // Byte lanes merge into the stored configuration so partial writes keep other bytes.
    always_comb begin
        mode_wr = mode_full;
        for (int i = 0; i < 4; i++) begin
            if (s_reg.w_strb[i]) begin
                mode_wr[i*8 +: 8] = s_reg.w_data[i*8 +: 8];
            end
        end
    end

    // Write decode and the watchdog events that a write causes.
    always_comb begin
        wr_go     = s_reg.aw_hold && s_reg.w_hold && !s_reg.bvalid;
        wr_mapped = (s_reg.aw_addr == `WWDT_CR_OFF) || (s_reg.aw_addr == `WWDT_MR_OFF)
                    || (s_reg.aw_addr == `WWDT_SR_OFF);
        mw_ok     = wr_go && (s_reg.aw_addr == `WWDT_MR_OFF) && !s_reg.mode_done;
        cr_key_ok = wr_go && (s_reg.aw_addr == `WWDT_CR_OFF) && s_reg.w_strb[3]
                    && (s_reg.w_data[`WWDT_KEY_HI:`WWDT_KEY_LO] == `WWDT_KEY);
        cr_bad    = wr_go && (s_reg.aw_addr == `WWDT_CR_OFF) && !cr_key_ok;
        rstt_req  = cr_key_ok && s_reg.w_strb[0] && s_reg.w_data[`WWDT_RSTT_BIT];
        // Above the limit is early; a limit at or above the reload never trips.
        win_bad    = s_reg.cnt > restart_window_limit;
        restart_ok = rstt_req && !win_bad;
        err_ev     = rstt_req && win_bad;
        presc_clr  = mw_ok || restart_ok;
    end

    // Halting keeps the prescaler running; only the count itself is frozen.
    always_comb begin
        running = !mode_full[`WWDT_DIS_BIT]
                  && !(debug_state && mode_full[`WWDT_DBGH_BIT])
                  && !(idle_mode && mode_full[`WWDT_IDLH_BIT]);
        unf_ev  = presc_tick && running && (s_reg.cnt == '0) && !presc_clr;
    end

    // Read decode; the status read is what clears the sticky flags.
    always_comb begin
        ar_go = s_axi_arvalid && s_reg.arready;
        sr_rd = ar_go && (s_axi_araddr == `WWDT_SR_OFF);
    end

    // Next state of the whole block.
    always_comb begin
        s_next = s_reg;

        // Address and data are captured independently, in either order.
        if (s_axi_awvalid && s_reg.awready) begin
            s_next.aw_hold = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_reg.wready) begin
            s_next.w_hold = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end

        // A write completes once both halves are held and no response is pending.
        if (wr_go) begin
            s_next.aw_hold = 1'b0;
            s_next.w_hold  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = wr_mapped ? `WWDT_RESP_OKAY : `WWDT_RESP_SLV;
        end

        // Later configuration writes are answered OKAY but leave it untouched.
        if (mw_ok) begin
            s_next.mode      = mode_wr[29:0];
            s_next.mode_done = 1'b1;
        end

        // Reloads take priority over a tick landing in the same cycle.
        if (mw_ok) begin
            s_next.cnt = mode_wr[`WWDT_WDV_HI:`WWDT_WDV_LO];
        end else if (restart_ok) begin
            s_next.cnt = counter_reload_value;
        end else if (presc_tick && running) begin
            if (s_reg.cnt == '0) begin
                s_next.cnt = counter_reload_value;
            end else begin
                s_next.cnt = s_reg.cnt - 1'b1;
            end
        end

        // Read channel; reads of the write-only control give zero.
        if (ar_go) begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = `WWDT_RESP_OKAY;
            case (s_axi_araddr)
                `WWDT_CR_OFF: s_next.rdata = '0;
                `WWDT_MR_OFF: s_next.rdata = mode_full;
                `WWDT_SR_OFF: begin
                    s_next.rdata = '0;
                    s_next.rdata[`WWDT_UNF_BIT] = s_reg.unf;
                    s_next.rdata[`WWDT_ERR_BIT] = s_reg.err;
                end
                default: begin
                    s_next.rdata = '0;
                    s_next.rresp = `WWDT_RESP_SLV;
                end
            endcase
        end

        // An event in the cycle of the status read survives it: set wins.
        s_next.unf   = unf_ev || (s_reg.unf && !sr_rd);
        s_next.err   = err_ev || (s_reg.err && !sr_rd);
        s_next.fault = (unf_ev && mode_full[`WWDT_RSTEN_BIT]) || err_ev
                       || (s_reg.fault && !sr_rd);
        s_next.irq   = s_next.mode[`WWDT_FIEN_BIT]
                       && (s_next.unf || s_next.err);
        s_next.proc_req = s_next.fault && s_next.mode[`WWDT_RSTEN_BIT]
                          && s_next.mode[`WWDT_RPROC_BIT];
        s_next.all_req  = s_next.fault && s_next.mode[`WWDT_RSTEN_BIT]
                          && !s_next.mode[`WWDT_RPROC_BIT];

        // Write ready is withheld while a captured half is held; read ready while read data is pending.
        s_next.awready = !s_next.aw_hold;
        s_next.wready  = !s_next.w_hold;
        s_next.arready = !s_next.rvalid;
    end

    // Any reset, including the one this block requests, restores the whole reset image.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_reg <= rst_val;
        end else begin
            s_reg <= s_next;
        end
    end

    // All outputs come straight from state flip-flops.
    assign s_axi_awready  = s_reg.awready;
    assign s_axi_wready   = s_reg.wready;
    assign s_axi_bvalid   = s_reg.bvalid;
    assign s_axi_bresp    = s_reg.bresp;
    assign s_axi_arready  = s_reg.arready;
    assign s_axi_rvalid   = s_reg.rvalid;
    assign s_axi_rresp    = s_reg.rresp;
    assign s_axi_rdata    = s_reg.rdata;
    assign wdt_fault      = s_reg.fault;
    assign fault_irq      = s_reg.irq;
    assign proc_reset_req = s_reg.proc_req;
    assign all_reset_req  = s_reg.all_req;

    // Checks on the watchdog behaviour.
    chk_reset_state: assert property (@(posedge core_clk) disable iff (rst)
        $past(rst) |-> (s_reg.cnt == 12'hFFF) && !s_reg.fault
                       && (s_reg.mode == MR_RST[29:0]))
        else $error("Reset state of counter or configuration is wrong.");

    chk_reload_value: assert property (@(posedge core_clk) disable iff (rst)
        mw_ok |=> (s_reg.cnt == counter_reload_value) && s_reg.mode_done)
        else $error("Configuration write did not reload the counter.");

    chk_mode_once: assert property (@(posedge core_clk) disable iff (rst)
        s_reg.mode_done |=> $stable(s_reg.mode))
        else $error("Configuration changed after its first write.");

    chk_key_guard: assert property (@(posedge core_clk) disable iff (rst)
        (cr_bad && !presc_tick && !mw_ok) |=> $stable(s_reg.cnt))
        else $error("Control write with a wrong key had an effect.");

    chk_restart_ok: assert property (@(posedge core_clk) disable iff (rst)
        (rstt_req && (s_reg.cnt <= restart_window_limit)) |=> (s_reg.cnt == counter_reload_value) ##1 !presc_tick)
        else $error("Restart inside the window did not reload.");

    chk_window_err: assert property (@(posedge core_clk) disable iff (rst)
        (rstt_req && (s_reg.cnt > restart_window_limit)) |=> s_reg.err && s_reg.fault)
        else $error("Early restart did not flag an error and fault.");

    chk_unf_flag: assert property (@(posedge core_clk) disable iff (rst)
        unf_ev |=> s_reg.unf && (s_reg.fault || !mode_full[`WWDT_RSTEN_BIT]))
        else $error("Underflow did not set its flag or fault.");

    chk_irq_gate: assert property (@(posedge core_clk) disable iff (rst)
        s_reg.irq == (mode_full[`WWDT_FIEN_BIT] && (s_reg.unf || s_reg.err)))
        else $error("Interrupt does not follow the flags and enable.");

    chk_status_clear: assert property (@(posedge core_clk) disable iff (rst)
        (sr_rd && !unf_ev && !err_ev) |=> !s_reg.unf && !s_reg.err && !s_reg.fault)
        else $error("Status read did not clear flags and fault.");

    chk_halt_freeze: assert property (@(posedge core_clk) disable iff (rst)
        (!running && !presc_clr) |=> $stable(s_reg.cnt))
        else $error("Counter moved while halted or disabled.");

    chk_reset_select: assert property (@(posedge core_clk) disable iff (rst)
        (s_reg.proc_req || s_reg.all_req) |-> s_reg.fault && mode_full[`WWDT_RSTEN_BIT]
            && (s_reg.proc_req == mode_full[`WWDT_RPROC_BIT]))
        else $error("Reset request does not match the select bit.");

    // Counting, holding and request checks; the open window also covers the reset default.
    chk_fault_hold: assert property (@(posedge core_clk) disable iff (rst)
        (s_reg.fault && !sr_rd) |=> s_reg.fault)
        else $error("Fault dropped before a status read or reset.");

    chk_unf_reload: assert property (@(posedge core_clk) disable iff (rst)
        unf_ev |=> (s_reg.cnt == counter_reload_value))
        else $error("Underflow did not reload the counter.");

    chk_tick_only: assert property (@(posedge core_clk) disable iff (rst)
        (!presc_tick && !presc_clr) |=> $stable(s_reg.cnt))
        else $error("Counter moved without a prescaler tick or reload.");

    chk_count_step: assert property (@(posedge core_clk) disable iff (rst)
        (presc_tick && running && !presc_clr && (s_reg.cnt != 12'h000))
            |=> (s_reg.cnt == $past(s_reg.cnt) - 12'h001))
        else $error("Counter did not step down by one on a tick.");

    chk_fault_request: assert property (@(posedge core_clk) disable iff (rst)
        (s_reg.fault && mode_full[`WWDT_RSTEN_BIT])
            |-> (s_reg.proc_req || s_reg.all_req))
        else $error("Enabled fault raised no reset request.");

    chk_window_open: assert property (@(posedge core_clk) disable iff (rst)
        (rstt_req && (restart_window_limit >= counter_reload_value) && (s_reg.cnt <= counter_reload_value)) |=> !$rose(s_reg.err))
        else $error("Restart with an open window raised an error.");

    chk_early_no_reload: assert property (@(posedge core_clk) disable iff (rst)
        (err_ev && !presc_tick) |=> $stable(s_reg.cnt))
        else $error("Early restart reloaded the counter.");

    cov_underflow: cover property (@(posedge core_clk) disable iff (rst) unf_ev);
    cov_window_err: cover property (@(posedge core_clk) disable iff (rst) err_ev);
    cov_restart: cover property (@(posedge core_clk) disable iff (rst) restart_ok);
    cov_flag_read: cover property (@(posedge core_clk) disable iff (rst)
        sr_rd && s_reg.fault);
    cov_halted_tick: cover property (@(posedge core_clk) disable iff (rst)
        presc_tick && !running);
endmodule // wwdt_top

/* tb/windowed_watchdog_timer_tb.sv */
// Self-checking bench for the windowed watchdog over its register bus.
`timescale 1ns/1ns
module windowed_watchdog_timer_tb;
    import wwdt_pkg::*;
    logic       core_clk = 1'b0;
    logic       bench_rst = 1'b1;
    logic       follow_en = 1'b0;
    logic       debug_state = 1'b0;
    logic       idle_mode = 1'b0;
    logic       awvalid = 1'b0;
    logic       wvalid = 1'b0;
    logic       arvalid = 1'b0;
    wwdt_addr_t awaddr = 4'h0;
    wwdt_addr_t araddr = 4'h0;
    wwdt_word_t wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hF;
    wwdt_word_t rdata;
    logic       rst, slow_clk_en, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic       wdt_fault, fault_irq, proc_reset_req, all_reset_req;
    int         error_cnt = 0;
    int         checks_done = 0;
    int         cyc = 0;
    int         n;

    // Clock at 25 MHz.
    always #20 core_clk = ~core_clk;

    wwdt_rstc_model RSTC (.core_clk(core_clk), .bench_rst(bench_rst), .follow_en(follow_en),
        .proc_reset_req(proc_reset_req), .all_reset_req(all_reset_req), .rst(rst),
        .slow_clk_en(slow_clk_en));

    // A short prescaler keeps every underflow within a few hundred cycles.
    wwdt_top #(.PRESC_DIV(4)) DUT (.core_clk(core_clk), .rst(rst), .slow_clk_en(slow_clk_en),
        .debug_state(debug_state), .idle_mode(idle_mode), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .wdt_fault(wdt_fault), .fault_irq(fault_irq),
        .proc_reset_req(proc_reset_req), .all_reset_req(all_reset_req));

    // Prints the verdict and ends the run.
    task automatic results();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Compares two words, with unknowns counted as mismatches.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Write: both halves offered together; the edge is judged from the level seen at negedge.
    task automatic wr(input wwdt_addr_t a, input wwdt_word_t d, input logic [1:0] er);
        logic aw_go, w_go, b_go;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge core_clk);
            aw_go = awvalid & awready;
            w_go = wvalid & wready;
            b_go = bvalid;
            if (b_go) chk({30'h00000000, bresp}, {30'h00000000, er});
            @(posedge core_clk);
            if (aw_go) awvalid <= 1'b0;
            if (w_go) wvalid <= 1'b0;
        end while (!b_go);
    endtask

    // Read one word and compare data and response.
    task automatic rd(input wwdt_addr_t a, input wwdt_word_t ed, input logic [1:0] er);
        logic ar_go, r_go;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge core_clk);
            ar_go = arvalid & arready;
            r_go = rvalid;
            if (r_go) chk(rdata, ed);
            if (r_go) chk({30'h00000000, rresp}, {30'h00000000, er});
            @(posedge core_clk);
            if (ar_go) arvalid <= 1'b0;
        end while (!r_go);
    endtask

    // Fault, interrupt, processor request and full request, in that order.
    task automatic outs(input logic [3:0] e);
        @(negedge core_clk);
        chk({28'h0000000, wdt_fault, fault_irq, proc_reset_req, all_reset_req},
            {28'h0000000, e});
        @(posedge core_clk);
    endtask

    // Counts cycles until the fault line rises, giving up after 400.
    task automatic wait_fault(output int cnt);
        cnt = 0;
        do begin
            @(negedge core_clk);
            cnt++;
        end while (!wdt_fault && cnt < 400);
        chk({31'h00000000, wdt_fault}, 32'h00000001);
        @(posedge core_clk);
    endtask

    // A hang is cut short well beyond the longest expected run.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            results();
        end
    end

    // Main sequence.
    initial begin
        repeat (10) @(posedge core_clk);
        bench_rst <= 1'b0;
        @(posedge core_clk);
        rd(4'h4, 32'h3FFF2FFF, 2'h0);
        rd(4'h8, 32'h00000000, 2'h0);
        rd(4'h0, 32'h00000000, 2'h0);
        rd(4'hC, 32'h00000000, 2'h2);
        wr(4'hC, 32'hFFFFFFFF, 2'h2);
        wr(4'h0, 32'hA5000001, 2'h0);
        rd(4'h8, 32'h00000000, 2'h0);
        // Reload 16, window 8, interrupt on, fault reset to the processor only.
        wr(4'h4, 32'h00087010, 2'h0);
        wr(4'h4, 32'h00000000, 2'h0);
        rd(4'h4, 32'h00087010, 2'h0);
        wr(4'h0, 32'h5A000001, 2'h0);
        // A strobe without the key byte must drop this early restart.
        wstrb <= 4'h1;
        wr(4'h0, 32'hA5000001, 2'h0);
        wstrb <= 4'hF;
        wr(4'h0, 32'hA5000000, 2'h0);
        rd(4'h8, 32'h00000000, 2'h0);
        wr(4'h0, 32'hA5000001, 2'h0);
        outs(4'hE);
        repeat (20) @(posedge core_clk);
        outs(4'hE);
        rd(4'h8, 32'h00000002, 2'h0);
        outs(4'h0);
        wait_fault(n);
        outs(4'hE);
        rd(4'h8, 32'h00000001, 2'h0);
        // The counter has fallen inside the window, so this restart is legal.
        repeat (100) @(posedge core_clk);
        wr(4'h0, 32'hA5000001, 2'h0);
        follow_en <= 1'b1;
        wait_fault(n);
        chk(32'(n >= 132 && n <= 142), 32'h00000001);
        repeat (4) @(posedge core_clk);
        follow_en <= 1'b0;
        outs(4'h0);
        rd(4'h4, 32'h3FFF2FFF, 2'h0);
        rd(4'h8, 32'h00000000, 2'h0);
        // Disabled timer, window 0: a restart still errs, but nothing underflows.
        wr(4'h4, 32'h00008010, 2'h0);
        wr(4'h0, 32'hA5000001, 2'h0);
        outs(4'h8);
        rd(4'h8, 32'h00000002, 2'h0);
        repeat (300) @(posedge core_clk);
        rd(4'h8, 32'h00000000, 2'h0);
        // Debug halt only, fault reset to all resets.
        bench_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        bench_rst <= 1'b0;
        @(posedge core_clk);
        wr(4'h4, 32'h10102010, 2'h0);
        idle_mode <= 1'b1;
        debug_state <= 1'b1;
        repeat (300) @(posedge core_clk);
        outs(4'h0);
        debug_state <= 1'b0;
        wait_fault(n);
        outs(4'h9);
        // Idle halt only: the count waits while idle and resumes afterwards.
        bench_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        bench_rst <= 1'b0;
        @(posedge core_clk);
        wr(4'h4, 32'h20102010, 2'h0);
        repeat (300) @(posedge core_clk);
        outs(4'h0);
        idle_mode <= 1'b0;
        wait_fault(n);
        outs(4'h9);
        results();
    end
endmodule // windowed_watchdog_timer_tb

/* tb/wwdt_rstc_model.sv */
// Reset controller and slow clock source that stand beside the watchdog.
`timescale 1ns/1ns
module wwdt_rstc_model (
    input  wire logic core_clk,
    input  wire logic bench_rst,
    input  wire logic follow_en,
    input  wire logic proc_reset_req,
    input  wire logic all_reset_req,
    output logic      rst,
    output logic      slow_clk_en
);
    logic [1:0] hold_cnt;

    // A slow enable on every second cycle keeps the prescaled ticks short.
    always_ff @(posedge core_clk) begin
        slow_clk_en <= bench_rst ? 1'b0 : ~slow_clk_en;
    end

    // A granted request holds reset for two cycles; requests are honoured only when enabled.
    always_ff @(posedge core_clk) begin
        if (bench_rst) begin
            hold_cnt <= 2'h0;
        end else if (hold_cnt != 2'h0) begin
            hold_cnt <= hold_cnt - 2'h1;
        end else if (follow_en && (proc_reset_req || all_reset_req)) begin
            hold_cnt <= 2'h2;
        end
    end

    // Bench reset and a granted watchdog reset drive the same line.
    assign rst = bench_rst || (hold_cnt != 2'h0);
endmodule // wwdt_rstc_model
